// file: design/rss_regs.vh
// reset source sequencer constants: register offsets, field positions, reset values, timing counts
// assumes the includer runs on a 20 MHz core clock and reaches registers over a plain port
`ifndef RSS_REGS_VH
`define RSS_REGS_VH
`define RSS_ADDR_BORCTL   4'h0
`define RSS_ADDR_PWRCTL   4'h1
`define RSS_ADDR_STATUS   4'h2
`define RSS_BC_SWEN       7
`define RSS_BC_FAST       6
`define RSS_BC_READY      0
`define RSS_BC_RESET      8'h80
`define RSS_BC_SWEN_RESET 1'b1
`define RSS_PC_OVERFLOW   7
`define RSS_PC_UNDERFLOW  6
`define RSS_PC_WATCHDOG   4
`define RSS_PC_PIN        3
`define RSS_PC_RESETINSTR 2
`define RSS_PC_POR        1
`define RSS_PC_BROWNOUT   0
`define RSS_PC_POR_VALUE  8'h1c
`define RSS_PC_WMASK      8'hdf
`define RSS_ST_TIMEOUT    1
`define RSS_ST_POWERDOWN  0
`define RSS_MODE_ON       2'h3
`define RSS_MODE_NOSLEEP  2'h2
`define RSS_MODE_SW       2'h1
`define RSS_MODE_OFF      2'h0
`define RSS_PUD_MS        64
`define RSS_LF_HZ         31000
`define RSS_PUD_TICKS     ((`RSS_PUD_MS * `RSS_LF_HZ) / 1000)
`define RSS_FILTER_CYC    4
`define RSS_SYNC_IDLE     4'h1
`endif

// file: design/rss_reset_sequencer.v
// reset source sequencer: combines reset sources and sequences core start-up
// assumes a free 20 MHz core_clk, a low-frequency tick from the always-on oscillator, async pin and monitor inputs
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "rss_regs.vh"
`default_nettype none
module rss_reset_sequencer #(
  parameter PUD_TICKS  = `RSS_PUD_TICKS,
  parameter FILTER_CYC = `RSS_FILTER_CYC
) (
  // clock and synchronous reset
  input  wire       core_clk,
  input  wire       rst,
  // register port, read data one cycle after the strobe
  input  wire [3:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata,
  // reset pin: input only, output enable kept low
  input  wire       externalResetPinIn,
  output reg        externalResetPinOut,
  output reg        externalResetPinOe,
  output reg        pinPullupEn,
  output reg        pinGpioIn,
  input  wire       softPullupReq,
  // configuration bits, static while running
  input  wire [1:0] brownoutModeSelect,
  input  wire       externalResetPinEnable,
  input  wire       lowVoltageProgramEnable,
  input  wire       lowPowerBrownoutEnable,
  input  wire       powerUpDelayEnable_n,
  input  wire       stackFaultResetEnable,
  // same-clock status from oscillator and band gap
  input  wire       oscStartupNeeded,
  input  wire       oscStartupDone,
  input  wire       lfTick,
  input  wire       bandgapReady,
  // supply monitors and programming exit, asynchronous
  input  wire       brownoutTrip,
  input  wire       lowPowerBrownoutTrip,
  input  wire       programModeExit,
  // one-cycle events and the sleep level from the core
  input  wire       watchdogTimeout,
  input  wire       resetInstruction,
  input  wire       stackOverflow,
  input  wire       stackUnderflow,
  input  wire       sleepMode,
  // reset and power control outputs
  output reg        coreReset,
  output reg        brownoutDetectorOn,
  output reg        bandgapForceOn,
  output reg        brownoutResetOut
);

  // start-up sequence at a glance:
  //   hold  - a power-class source is present (monitors, programming exit)
  //   delay - power-up delay counts low-frequency ticks, skipped when disabled
  //   wait  - oscillator settle, reset pin release, band gap ready in modes 11 and 10
  //   run   - core out of reset; any source sends it back
  // power-class sources return to hold and run the delay again
  // soft sources (watchdog, reset instruction, stack, pin) go straight to wait,
  // so a short event costs one cycle of core reset and no delay
  // the delay keeps counting while the pin is low, so a pin held past the
  // delay lets the core start right after the filtered pin goes high
  //
  // cause flags live in one byte:
  //   bit 7 overflow, set by hardware
  //   bit 6 underflow, set by hardware
  //   bit 5 unused, reads zero, writes dropped
  //   bit 4 watchdog, active low
  //   bit 3 reset pin, active low
  //   bit 2 reset instruction, active low
  //   bit 1 power-on, active low
  //   bit 0 brown-out, active low, shared by both monitors
  // hardware updates are assigned after the software write, so an event
  // in the same cycle as a write always wins
  //
  // status byte: bit 1 timeout, bit 0 power-down, both active low
  // programming exit restores both to one, like a power-on
  //
  // limitation: soft events act only while in run; in the other states
  // the core is already held, and all flags but the pin flag take note of them
  // limitation: wake from sleep is not delayed here; sleep only gates
  // the detector in mode 10 and clears the power-down flag
  //
  // all asynchronous inputs pass three flops; a level counts once the
  // second and third agree, which costs three to four cycles of latency
  // but keeps a metastable sample out of the state machine
  // the pin then needs a further filter span before it is believed,
  // so a pin press reaches the core about eight cycles late
  //
  // the power-up delay counter is 32 bits wide so that any tick count a
  // slower or faster low-frequency source might need still fits
  // the delay restarts from zero on every entry to its state, so a
  // dropout in mid-delay always buys a full delay again
  //
  // all outputs are registered; core reset follows the next state so it
  // leaves reset on the same edge the sequencer enters run

  localparam [3:0] ST_HOLD   = 4'h1;
  localparam [3:0] ST_DELAY  = 4'h2;
  localparam [3:0] ST_WAIT   = 4'h4;
  localparam [3:0] ST_RUN    = 4'h8;
  localparam       NSYNC     = 4;
  localparam [3:0] SYNC_IDLE = `RSS_SYNC_IDLE;

  // synchronised levels: bit 0 pin, 1 brown-out, 2 low-power monitor, 3 programming exit
  wire [3:0] srcRaw;
  wire [3:0] srcLevel;
  wire       pinLevel;
  wire       brownLevel;
  wire       lpLevel;
  wire       pgmLevel;
  reg  [7:0] pinFilt_reg;
  reg        pinFiltered_reg;
  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  reg [31:0] pudCnt_reg;
  reg        pudDone_reg;
  reg        swEnable_reg;
  reg        fastStart_reg;
  reg  [7:0] pwrCtl_reg;
  reg        timeoutFlag_n_reg;
  reg        powerdownFlag_n_reg;
  reg        porSeen_reg;
  wire       pinEnabled;
  wire       detectorActive;
  wire       combinedBrownout;
  wire       stackFault;
  wire       softReset;
  wire       powerReset;
  wire       pinHold;
  wire       bcWrite;
  wire       pcWrite;

  // raw asynchronous sources in synchroniser order
  assign srcRaw = {programModeExit, lowPowerBrownoutTrip, brownoutTrip, externalResetPinIn};

  // synchronise async sources
  // one chain per source; stage 0 is read only by stage 1
  // reset loads the idle level so release shows no false edge
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : gSync
      reg [2:0] stage_reg;
      reg       level_reg;
      always @(posedge core_clk) begin
        if (rst) begin
          stage_reg <= {3{SYNC_IDLE[gi]}};
          level_reg <= SYNC_IDLE[gi];
        end else begin
          stage_reg <= {stage_reg[1:0], srcRaw[gi]};
          // a change counts once stages two and three agree
          if (stage_reg[1] == stage_reg[2])
            level_reg <= stage_reg[2];
        end
      end
      assign srcLevel[gi] = level_reg;
    end
  endgenerate

  // named views of the synchronised levels
  assign pinLevel   = srcLevel[0];
  assign brownLevel = srcLevel[1];
  assign lpLevel    = srcLevel[2];
  assign pgmLevel   = srcLevel[3];

  // pin filter: level must hold FILTER_CYC cycles
  // a pulse shorter than the filter never reaches the sequencer;
  // the filter runs whether or not the pin function is on, so turning
  // it on with the pin already low takes effect at once
  always @(posedge core_clk) begin
    if (rst) begin
      pinFilt_reg     <= 8'h00;
      pinFiltered_reg <= 1'b1;       // idle high, no false press after reset
    end else if (pinLevel == pinFiltered_reg) begin
      pinFilt_reg <= 8'h00;
    end else if (pinFilt_reg == FILTER_CYC[7:0] - 8'h01) begin
      pinFilt_reg     <= 8'h00;
      pinFiltered_reg <= pinLevel;
    end else begin
      pinFilt_reg <= pinFilt_reg + 8'h01;
    end
  end

  // pin off only when both bits low
  assign pinEnabled = externalResetPinEnable | lowVoltageProgramEnable;
  assign pinHold = pinEnabled & ~pinFiltered_reg;

  assign detectorActive = (brownoutModeSelect == `RSS_MODE_ON) |
                          ((brownoutModeSelect == `RSS_MODE_NOSLEEP) & ~sleepMode) |
                          ((brownoutModeSelect == `RSS_MODE_SW) & swEnable_reg);
  // low-power trip ORed, gated by its own config bit
  // the standard detector counts only while its mode has it on;
  // the low-power monitor answers to nothing but its own bit
  assign combinedBrownout = (detectorActive & brownLevel) | (lowPowerBrownoutEnable & lpLevel);
  assign stackFault = stackFaultResetEnable & (stackOverflow | stackUnderflow);
  // soft sources: no delay, straight to the wait stage
  assign softReset  = watchdogTimeout | resetInstruction | stackFault;
  // programming exit treated as power-on
  // same path as a supply dropout, so the delay runs again
  assign powerReset = combinedBrownout | pgmLevel;
  assign bcWrite = regWrite & (regAddr == `RSS_ADDR_BORCTL);
  assign pcWrite = regWrite & (regAddr == `RSS_ADDR_PWRCTL);

  // start-up sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (!powerReset)
          state_next = ST_DELAY;
      end
      ST_DELAY: begin
        // optional power-up delay
        // the pin is not looked at here: delay and pin run side by side
        if (powerReset)
          state_next = ST_HOLD;
        else if (powerUpDelayEnable_n || pudDone_reg)
          state_next = ST_WAIT;
      end
      // wait holds until every start condition is met at once
      ST_WAIT: begin
        // oscillator, pin and band gap all checked in the same cycle
        if (powerReset)
          state_next = ST_HOLD;
        else if ((!oscStartupNeeded || oscStartupDone) && !pinHold &&
                 (brownoutModeSelect == `RSS_MODE_SW || brownoutModeSelect == `RSS_MODE_OFF || bandgapReady))
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (powerReset)
          state_next = ST_HOLD;
        else if (softReset || pinHold)
          state_next = ST_WAIT;
      end
      default: state_next = ST_HOLD;
    endcase
  end

  // state and power-up timer, counted on low-frequency ticks
  // counting ticks rather than core cycles keeps the delay tied to the
  // always-on oscillator, whatever the core clock happens to be
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg   <= ST_HOLD;
      pudCnt_reg  <= 32'h0;
      pudDone_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // count lf ticks to terminal
      // done stays set until the state is left, then both clear
      if (state_reg != ST_DELAY) begin
        pudCnt_reg  <= 32'h0;
        pudDone_reg <= 1'b0;
      end else if (lfTick && !pudDone_reg) begin
        if (pudCnt_reg >= PUD_TICKS - 1)
          pudDone_reg <= 1'b1;
        pudCnt_reg <= pudCnt_reg + 32'h1;
      end
    end
  end

  // control register and reset-cause flags; hardware set wins over write
  always @(posedge core_clk) begin
    if (rst) begin
      swEnable_reg        <= `RSS_BC_SWEN_RESET;
      fastStart_reg       <= 1'b0;
      pwrCtl_reg          <= `RSS_PC_POR_VALUE;
      timeoutFlag_n_reg   <= 1'b1;
      powerdownFlag_n_reg <= 1'b1;
      porSeen_reg         <= 1'b0;
    end else begin
      // only bits 7 and 6 stored
      if (bcWrite) begin
        swEnable_reg  <= regWdata[`RSS_BC_SWEN];
        fastStart_reg <= regWdata[`RSS_BC_FAST];
      end
      if (pcWrite)
        pwrCtl_reg <= regWdata & `RSS_PC_WMASK;
      porSeen_reg <= 1'b1;
      // power-on value on programming exit
      // the whole byte is reloaded while the exit level stands, so a
      // software write in that window is lost on purpose
      if (pgmLevel) begin
        pwrCtl_reg <= `RSS_PC_POR_VALUE;
        timeoutFlag_n_reg   <= 1'b1;
        powerdownFlag_n_reg <= 1'b1;
      end else begin
        // shared brown-out flag cleared
        // no way to tell which monitor fired: both land on one bit
        if (combinedBrownout)
          pwrCtl_reg[`RSS_PC_BROWNOUT] <= 1'b0;
        if (watchdogTimeout) begin
          pwrCtl_reg[`RSS_PC_WATCHDOG] <= 1'b0;
          timeoutFlag_n_reg <= 1'b0;
        end
        // power-down flag cleared by the core's sleep level; only reset or programming exit sets it again
        if (sleepMode)
          powerdownFlag_n_reg <= 1'b0;
        if (resetInstruction)
          pwrCtl_reg[`RSS_PC_RESETINSTR] <= 1'b0;
        // pin flag marks a press seen while running only
        if (pinHold && state_reg == ST_RUN)
          pwrCtl_reg[`RSS_PC_PIN] <= 1'b0;
        // cause flags
        // the two stack flags set high, unlike the rest, and software clears them
        if (stackFaultResetEnable && stackOverflow)
          pwrCtl_reg[`RSS_PC_OVERFLOW] <= 1'b1;
        if (stackFaultResetEnable && stackUnderflow)
          pwrCtl_reg[`RSS_PC_UNDERFLOW] <= 1'b1;
        if (!porSeen_reg)
          pwrCtl_reg[`RSS_PC_POR] <= 1'b0;
      end
    end
  end

  // register map:
  //   offset 0 brown-out control: bit 7 software enable, bit 6 fast start,
  //            bits 5..1 read zero, bit 0 ready (read only)
  //   offset 1 cause flags, bit 5 reads zero
  //   offset 2 status flags, read only
  //   other offsets read zero and drop writes
  // read data stand for one cycle and return to zero, so a stale value
  // can never be mistaken for a fresh read
  // ready is live: detector on and band gap settled, not a stored bit
  // registered outputs and read port
  always @(posedge core_clk) begin
    if (rst) begin
      regRdata            <= 8'h00;
      coreReset           <= 1'b1;
      brownoutDetectorOn  <= 1'b0;
      bandgapForceOn      <= 1'b0;
      brownoutResetOut    <= 1'b0;
      externalResetPinOut <= 1'b0;
      externalResetPinOe  <= 1'b0;
      pinPullupEn         <= 1'b1;
      pinGpioIn           <= 1'b1;
    end else begin
      coreReset          <= (state_next != ST_RUN);
      brownoutDetectorOn <= detectorActive;
      // fast start only in modes 10 and 01
      bandgapForceOn <= fastStart_reg &
                        (brownoutModeSelect == `RSS_MODE_NOSLEEP || brownoutModeSelect == `RSS_MODE_SW);
      brownoutResetOut <= combinedBrownout;
      externalResetPinOut <= 1'b0;
      externalResetPinOe  <= 1'b0;
      // pull-up fixed when enabled, software otherwise
      pinPullupEn <= pinEnabled | softPullupReq;
      // gpio view of the pin, valid whichever function the pin has
      // taken before the filter so short pulses still show
      pinGpioIn   <= pinLevel;
      regRdata <= 8'h00;
      if (regRead) begin
        case (regAddr)
          `RSS_ADDR_BORCTL: regRdata <= {swEnable_reg, fastStart_reg, 5'h00, detectorActive & bandgapReady};
          `RSS_ADDR_PWRCTL: regRdata <= pwrCtl_reg;
          `RSS_ADDR_STATUS: regRdata <= {6'h00, timeoutFlag_n_reg, powerdownFlag_n_reg};
          default:          regRdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/rss_chk.sv
// checker: port relations of the reset source sequencer
// assumes a bind into rss_reset_sequencer, one core_clk domain
`timescale 1ns/1ps
`default_nettype none
module rss_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [3:0] regAddr,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       externalResetPinIn,
  input wire logic       externalResetPinOut,
  input wire logic       externalResetPinOe,
  input wire logic       pinPullupEn,
  input wire logic [1:0] brownoutModeSelect,
  input wire logic       externalResetPinEnable,
  input wire logic       lowVoltageProgramEnable,
  input wire logic       lowPowerBrownoutEnable,
  input wire logic       brownoutTrip,
  input wire logic       lowPowerBrownoutTrip,
  input wire logic       coreReset,
  input wire logic       bandgapForceOn,
  input wire logic       brownoutResetOut
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  // read data stands one cycle only
  chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside read slot");
  chk_bits_unused: assert property ($past(regRead && regAddr == 4'h0) |-> regRdata[5:1] == 5'h00)
    else $error("unused control bits nonzero");
  chk_fast_ignored: assert property (brownoutModeSelect[1] == brownoutModeSelect[0] |=> !bandgapForceOn)
    else $error("fast start acted in modes 11 or 00");
  chk_pin_undriven: assert property (!externalResetPinOe && !externalResetPinOut)
    else $error("reset pin driven");
  // twelve low samples are far past sync plus filter
  chk_pin_hold: assert property ((externalResetPinEnable && !externalResetPinIn)[*8] ##1
    (externalResetPinEnable && !externalResetPinIn)[*4] |-> coreReset)
    else $error("low reset pin did not hold reset");
  chk_lp_hold: assert property ((lowPowerBrownoutEnable && lowPowerBrownoutTrip)[*8]
    |-> coreReset && brownoutResetOut)
    else $error("low-power trip did not hold reset");
  chk_lp_off: assert property ((!lowPowerBrownoutEnable && !brownoutTrip)[*8] |-> !brownoutResetOut)
    else $error("brown-out out while both sources quiet");
  chk_pullup_on: assert property (externalResetPinEnable || lowVoltageProgramEnable |=> pinPullupEn)
    else $error("pull-up off with pin function on");
endmodule
bind rss_reset_sequencer rss_chk i_chk (.core_clk, .rst, .regAddr, .regRead, .regRdata, .externalResetPinIn,
  .externalResetPinOut, .externalResetPinOe, .pinPullupEn, .brownoutModeSelect, .externalResetPinEnable,
  .lowVoltageProgramEnable, .lowPowerBrownoutEnable, .brownoutTrip, .lowPowerBrownoutTrip, .coreReset,
  .bandgapForceOn, .brownoutResetOut);
`default_nettype wire

// file: testbench/rss_partner.sv
// partner: reset pin with weak pull-up and two supply monitors
// assumes the bench sets request levels right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module rss_partner (
  input  wire logic pullLow,
  input  wire logic vddLow,
  input  wire logic lpVddLow,
  input  wire logic dutPinOut,
  input  wire logic dutPinOe,
  output wire logic pinLevel,
  output wire logic borTrip,
  output wire logic lpTrip
);
  // pin pulled up unless a party drives it low
  assign pinLevel = !(pullLow || (dutPinOe && !dutPinOut));
  // monitors are async, so trips land off the clock edge
  assign #7 borTrip = vddLow;
  assign #7 lpTrip = lpVddLow;
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// bench: register and reset-source sequences for the sequencer
// assumes rss_partner on pin and supply lines, 50 ns clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic [3:0] regAddr, evt;
  logic [7:0] regWdata, regRdata;
  logic [1:0] brownoutModeSelect;
  logic [1:0] tickCnt = 2'h0;
  logic lfTick = 1'b0;
  logic core_clk, rst, regWrite, regRead, softPullupReq, externalResetPinEnable, lowVoltageProgramEnable;
  logic lowPowerBrownoutEnable, powerUpDelayEnable_n, stackFaultResetEnable, oscStartupNeeded, oscStartupDone;
  logic bandgapReady, programModeExit, sleepMode, pullLow, vddLow, lpVddLow;
  logic externalResetPinOut, externalResetPinOe, pinPullupEn, pinGpioIn, coreReset, brownoutDetectorOn;
  logic bandgapForceOn, brownoutResetOut;
  wire externalResetPinIn, brownoutTrip, lowPowerBrownoutTrip;
  wire watchdogTimeout, resetInstruction, stackOverflow, stackUnderflow;
  int errors, check_count, m;
  // one-cycle event pulses share a vector
  assign {stackUnderflow, stackOverflow, resetInstruction, watchdogTimeout} = evt;
  rss_reset_sequencer #(.PUD_TICKS(4)) i_dut (.*);
  rss_partner i_far (.pullLow, .vddLow, .lpVddLow, .dutPinOut(externalResetPinOut), .dutPinOe(externalResetPinOe),
    .pinLevel(externalResetPinIn), .borTrip(brownoutTrip), .lpTrip(lowPowerBrownoutTrip));
  // clock and a slow tick every fourth cycle
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    tickCnt <= tickCnt + 2'h1;
    lfTick <= &tickCnt;
  end
  task automatic chk(input logic [7:0] exp, got, input string nm);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  // outputs are read 1 ns after the edge, once settled
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    tick(1);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] msk, exp);
    regAddr <= a;
    regRead <= 1'b1;
    tick(1);
    regRead <= 1'b0;
    chk(exp, regRdata & msk, "regRdata");
    tick(1);
  endtask
  task automatic pulse(input logic [3:0] p);
    evt <= p;
    tick(1);
    evt <= 4'h0;
  endtask
  task automatic isRst(input logic e);
    chk({7'h00, e}, {7'h00, coreReset}, "coreReset");
  endtask
  task automatic waitRun(input int n);
    for (int i = 0; i < n && coreReset !== 1'b0; i++) tick(1);
    isRst(1'b0);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    {regAddr, regWdata, regWrite, regRead, evt, softPullupReq, sleepMode} = '0;
    {lowVoltageProgramEnable, stackFaultResetEnable, programModeExit, pullLow, vddLow, lpVddLow} = '0;
    {brownoutModeSelect, powerUpDelayEnable_n} = '0;
    {externalResetPinEnable, lowPowerBrownoutEnable, oscStartupNeeded, oscStartupDone, bandgapReady} = '1;
    rst = 1'b1;
    tick(5);
    rst <= 1'b0;
    tick(10);
    isRst(1'b1);
    waitRun(300);
    rd(4'h1, 8'hfe, 8'h1c);
    rd(4'h2, 8'h03, 8'h03);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'hff, 8'h00);
    $display("done power-on");
    wr(4'h0, 8'hff);
    for (m = 0; m < 4; m++) begin
      brownoutModeSelect <= m[1:0];
      tick(4);
      chk({7'h00, m == 1 || m == 2}, {7'h00, bandgapForceOn}, "bandgapForceOn");
      chk({7'h00, m != 0}, {7'h00, brownoutDetectorOn}, "brownoutDetectorOn");
      rd(4'h0, 8'hff, 8'hc0 | (m != 0));
    end
    brownoutModeSelect <= 2'h2;
    sleepMode <= 1'b1;
    tick(4);
    rd(4'h0, 8'h01, 8'h00);
    sleepMode <= 1'b0;
    brownoutModeSelect <= 2'h1;
    wr(4'h0, 8'h00);
    tick(2);
    rd(4'h0, 8'hff, 8'h00);
    chk(8'h00, {7'h00, bandgapForceOn}, "bandgapForceOn");
    wr(4'h0, 8'h80);
    $display("done control register");
    pulse(4'h2);
    isRst(1'b1);
    waitRun(100);
    rd(4'h1, 8'h04, 8'h00);
    pulse(4'h1);
    isRst(1'b1);
    waitRun(100);
    rd(4'h1, 8'h10, 8'h00);
    rd(4'h2, 8'h02, 8'h00);
    pulse(4'h4);
    tick(8);
    isRst(1'b0);
    stackFaultResetEnable <= 1'b1;
    wr(4'h1, 8'h1f);
    pulse(4'h8);
    waitRun(100);
    rd(4'h1, 8'hc0, 8'h40);
    $display("done soft resets");
    pullLow <= 1'b1;
    tick(3);
    pullLow <= 1'b0;
    tick(12);
    isRst(1'b0);
    pullLow <= 1'b1;
    tick(20);
    isRst(1'b1);
    pullLow <= 1'b0;
    waitRun(12);
    rd(4'h1, 8'h08, 8'h00);
    externalResetPinEnable <= 1'b0;
    softPullupReq <= 1'b1;
    pullLow <= 1'b1;
    tick(20);
    isRst(1'b0);
    chk(8'h02, {6'h00, pinPullupEn, pinGpioIn}, "pullup gpio");
    lowVoltageProgramEnable <= 1'b1;
    tick(20);
    isRst(1'b1);
    pullLow <= 1'b0;
    waitRun(12);
    $display("done reset pin");
    lowPowerBrownoutEnable <= 1'b0;
    lpVddLow <= 1'b1;
    tick(12);
    isRst(1'b0);
    lowPowerBrownoutEnable <= 1'b1;
    tick(12);
    isRst(1'b1);
    lpVddLow <= 1'b0;
    waitRun(300);
    rd(4'h1, 8'h01, 8'h00);
    wr(4'h1, 8'h1f);
    vddLow <= 1'b1;
    tick(12);
    chk(8'h01, {7'h00, brownoutResetOut}, "brownoutResetOut");
    vddLow <= 1'b0;
    waitRun(300);
    rd(4'h1, 8'h01, 8'h00);
    $display("done brown-out");
    wr(4'h1, 8'h1f);
    pullLow <= 1'b1;
    programModeExit <= 1'b1;
    tick(4);
    programModeExit <= 1'b0;
    tick(50);
    isRst(1'b1);
    pullLow <= 1'b0;
    waitRun(12);
    rd(4'h1, 8'h02, 8'h00);
    $display("done program exit");
    conclude;
  end
  // hang guard, about six times the expected run
  initial begin
    #100000;
    errors++;
    conclude;
  end
endmodule
`default_nettype wire
